// *** ssr_pkg.sv ***
package ssr_pkg;
    localparam int STAT_W = 12;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_SET = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h4;
    localparam int BIT_TX_HOLD_EMPTY = 0;
    localparam int BIT_TX_ALL_SENT = 1;
    localparam int BIT_TX_DMA_DONE = 2;
    localparam int BIT_TX_DMA_ZERO = 3;
    localparam int BIT_RX_READY = 4;
    localparam int BIT_RX_OVERRUN = 5;
    localparam int BIT_RX_DMA_DONE = 6;
    localparam int BIT_RX_DMA_ZERO = 7;
    localparam int BIT_CMP0 = 8;
    localparam int BIT_CMP1 = 9;
    localparam int BIT_TX_SYNC = 10;
    localparam int BIT_RX_SYNC = 11;
    localparam int BIT_TX_EN = 16;
    localparam int BIT_RX_EN = 17;
    localparam logic [STAT_W-1:0] MASK_RESET = 12'h000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// *** ssr_evt_if.sv ***
interface ssr_evt_if;
    import ssr_pkg::*;
    logic [5:0] ev;
    logic rd_clear;
    logic [5:0] flags;
    modport owner (input ev, input rd_clear, output flags);
    modport user (output ev, output rd_clear, input flags);
endinterface

// *** ssr_sticky.sv ***
module ssr_sticky
    import ssr_pkg::*;
#(
    parameter int N = 6
) (
    input wire logic i_clk,
    input wire logic i_reset,
    ssr_evt_if.owner bus
);
    typedef struct packed {
        logic [N-1:0] flag;
    } ssr_sticky_st_t;
    ssr_sticky_st_t st;
    ssr_sticky_st_t next_st;

    initial begin
        if (N < 1 || N > 6) $error("ssr_sticky: N out of range");
    end

    always_comb begin
        next_st = st;
        for (int k = 0; k < N; k++) begin
            if (bus.ev[k]) begin
                next_st.flag[k] = 1'b1;
            end else if (bus.rd_clear) begin
                next_st.flag[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.flags = st.flag;
endmodule

// *** ssr_regs.sv ***
// What this block does
// - Status bit 0 is high when the transmit holding register is empty, low while a word waits.
// - Status bit 1 is high when the holding register is empty and the shifter is idle, so also after reset before any word.
// - Status bit 2 is high once the transmit DMA count reached zero since the last count write.
// - Status bit 3 is high when transmit count and next count are both zero.
// - Status bit 4 is high while the receive holding register holds a word.
// - Status bit 5 sets when a received word overwrites an unread one and holds until a status read.
// - Status bit 6 sets when the receive DMA count reaches zero and clears on a receive count write.
// - Status bit 7 is high when receive count and next count are both zero.
// - Status bits 8 and 9 latch compare matches until the next status read.
// - Status bits 10 and 11 latch frame sync events until the next status read.
// - Writing ones to the enable-set register enables those sources, zeros do nothing.
// - Writing ones to the enable-clear register disables those sources, zeros do nothing.
// - The mask view register reads one for each enabled source.
module ssr_regs
    import ssr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic O_IRQ,
    input wire logic I_TX_HOLD_LOAD,
    input wire logic I_TX_SHIFT_TAKE,
    input wire logic I_TX_SHIFT_DONE,
    input wire logic I_RX_WORD_IN,
    input wire logic I_RX_WORD_READ,
    input wire logic [CNT_W-1:0] I_TX_DMA_COUNT,
    input wire logic [CNT_W-1:0] I_TX_DMA_NEXT_COUNT,
    input wire logic [CNT_W-1:0] I_RX_DMA_COUNT,
    input wire logic [CNT_W-1:0] I_RX_DMA_NEXT_COUNT,
    input wire logic I_TX_COUNT_WRITE,
    input wire logic I_RX_COUNT_WRITE,
    input wire logic I_CMP0_HIT,
    input wire logic I_CMP1_HIT,
    input wire logic I_TX_SYNC_EV,
    input wire logic I_RX_SYNC_EV,
    output logic O_TX_ENABLED,
    output logic O_RX_ENABLED
);
    typedef struct packed {
        logic tx_hold_full;
        logic tx_shift_busy;
        logic rx_full;
        logic tx_done_flag;
        logic rx_done_flag;
        logic [CNT_W-1:0] tx_cnt_prev;
        logic [CNT_W-1:0] rx_cnt_prev;
        logic [STAT_W-1:0] mask;
        logic tx_en;
        logic rx_en;
        logic [31:0] rdata;
        logic irq;
    } ssr_state_t;

    ssr_state_t st;
    ssr_state_t next_st;
    logic [STAT_W-1:0] status;
    logic [31:0] status_word;
    logic rd_status;
    logic tx_hit_zero;
    logic rx_hit_zero;

    ssr_evt_if ev_bus ();

    initial begin
        if (CNT_W < 1 || CNT_W > 32) $error("ssr_regs: CNT_W out of range");
    end

    assign rd_status = I_RD && (I_ADDR == OFS_STATUS);
    // count falling to zero marks end of a dma transfer
    assign tx_hit_zero = (I_TX_DMA_COUNT == '0) && (st.tx_cnt_prev != '0);
    assign rx_hit_zero = (I_RX_DMA_COUNT == '0) && (st.rx_cnt_prev != '0);

    // overrun when a word lands on an unread one
    assign ev_bus.ev[0] = I_RX_WORD_IN && st.rx_full && !I_RX_WORD_READ;
    assign ev_bus.ev[1] = I_CMP0_HIT;
    assign ev_bus.ev[2] = I_CMP1_HIT;
    assign ev_bus.ev[3] = I_TX_SYNC_EV;
    assign ev_bus.ev[4] = I_RX_SYNC_EV;
    assign ev_bus.ev[5] = 1'b0;
    assign ev_bus.rd_clear = rd_status;

    ssr_sticky #(.N(6)) u_sticky (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .bus(ev_bus)
    );

    always_comb begin
        status = '0;
        status[BIT_TX_HOLD_EMPTY] = !st.tx_hold_full;
        status[BIT_TX_ALL_SENT] = !st.tx_hold_full && !st.tx_shift_busy;
        status[BIT_TX_DMA_DONE] = st.tx_done_flag;
        status[BIT_TX_DMA_ZERO] = (I_TX_DMA_COUNT == '0) && (I_TX_DMA_NEXT_COUNT == '0);
        status[BIT_RX_READY] = st.rx_full;
        status[BIT_RX_OVERRUN] = ev_bus.flags[0];
        status[BIT_RX_DMA_DONE] = st.rx_done_flag;
        status[BIT_RX_DMA_ZERO] = (I_RX_DMA_COUNT == '0) && (I_RX_DMA_NEXT_COUNT == '0);
        status[BIT_CMP0] = ev_bus.flags[1];
        status[BIT_CMP1] = ev_bus.flags[2];
        status[BIT_TX_SYNC] = ev_bus.flags[3];
        status[BIT_RX_SYNC] = ev_bus.flags[4];
    end

    always_comb begin
        status_word = '0;
        status_word[STAT_W-1:0] = status;
        status_word[BIT_TX_EN] = st.tx_en;
        status_word[BIT_RX_EN] = st.rx_en;
    end

    always_comb begin
        next_st = st;
        next_st.tx_cnt_prev = I_TX_DMA_COUNT;
        next_st.rx_cnt_prev = I_RX_DMA_COUNT;

        // a load while the shifter takes the old word keeps the holding register full
        if (I_TX_HOLD_LOAD) begin
            next_st.tx_hold_full = 1'b1;
        end else if (I_TX_SHIFT_TAKE) begin
            next_st.tx_hold_full = 1'b0;
        end
        // shifter busy from take to done
        if (I_TX_SHIFT_TAKE && st.tx_hold_full) begin
            next_st.tx_shift_busy = 1'b1;
        end else if (I_TX_SHIFT_DONE) begin
            next_st.tx_shift_busy = 1'b0;
        end

        if (I_RX_WORD_IN) begin
            next_st.rx_full = 1'b1;
        end else if (I_RX_WORD_READ) begin
            next_st.rx_full = 1'b0;
        end

        // reaching zero wins over count write
        if (tx_hit_zero) begin
            next_st.tx_done_flag = 1'b1;
        end else if (I_TX_COUNT_WRITE) begin
            next_st.tx_done_flag = 1'b0;
        end
        if (rx_hit_zero) begin
            next_st.rx_done_flag = 1'b1;
        end else if (I_RX_COUNT_WRITE) begin
            next_st.rx_done_flag = 1'b0;
        end

        if (I_WR) begin
            if (I_ADDR == OFS_IRQ_SET) begin
                next_st.mask = st.mask | I_WDATA[STAT_W-1:0];
            end else if (I_ADDR == OFS_IRQ_CLR) begin
                next_st.mask = st.mask & ~I_WDATA[STAT_W-1:0];
            end else if (I_ADDR == OFS_CTRL) begin
                next_st.tx_en = I_WDATA[0];
                next_st.rx_en = I_WDATA[1];
            end
        end

        next_st.rdata = RDATA_RESET;
        if (I_RD) begin
            if (I_ADDR == OFS_STATUS) begin
                next_st.rdata = status_word;
            end else if (I_ADDR == OFS_IRQ_MASK) begin
                next_st.rdata[STAT_W-1:0] = st.mask;
            end else if (I_ADDR == OFS_CTRL) begin
                next_st.rdata[1:0] = {st.rx_en, st.tx_en};
            end
        end

        next_st.irq = |(status & st.mask);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            st <= '0;
            st.mask <= MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign O_RDATA = st.rdata;
    assign O_IRQ = st.irq;
    assign O_TX_ENABLED = st.tx_en;
    assign O_RX_ENABLED = st.rx_en;
endmodule

// *** ssr_checker.sv ***
module ssr_checker
    import ssr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_RX_WORD_IN,
    input wire logic I_RX_WORD_READ,
    input wire logic [CNT_W-1:0] I_TX_DMA_COUNT,
    input wire logic [CNT_W-1:0] I_TX_DMA_NEXT_COUNT,
    input wire logic I_CMP0_HIT,
    input wire logic I_CMP1_HIT,
    input wire logic I_TX_SYNC_EV,
    input wire logic I_RX_SYNC_EV
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    wire rs = I_RD && I_ADDR == OFS_STATUS;
    wire ev = I_CMP0_HIT | I_CMP1_HIT | I_TX_SYNC_EV | I_RX_SYNC_EV | I_RX_WORD_IN;
    // the one idle cycle matches the gap the software port leaves between calls
    sequence wr_mask(a);
        I_WR && I_ADDR == a ##1 !I_WR ##1 I_RD && I_ADDR == OFS_IRQ_MASK;
    endsequence
    sequence two_words;
        (I_RX_WORD_IN && !I_RX_WORD_READ)[*2] ##1 (!I_RD && !I_RX_WORD_READ);
    endsequence
    rdata_idle_a: assert property (!I_RD |=> O_RDATA == 32'h0) else $error("read data not idle");
    ovr_set_a: assert property (two_words ##1 rs |=> O_RDATA[BIT_RX_OVERRUN])
        else $error("overrun not reported");
    sticky_clear_a: assert property ((rs && !ev) ##1 (!I_RD && !ev) ##1 (rs && !ev)
        |=> O_RDATA[11:8] == 4'h0 && !O_RDATA[5]) else $error("sticky bit not cleared");
    cmp_latch_a: assert property (I_CMP0_HIT ##1 !I_RD ##1 rs |=> O_RDATA[BIT_CMP0])
        else $error("compare not latched");
    sync_latch_a: assert property (I_RX_SYNC_EV ##1 !I_RD ##1 rs |=> O_RDATA[BIT_RX_SYNC])
        else $error("sync not latched");
    tx_zero_flag_a: assert property (rs && $stable(I_TX_DMA_COUNT) && $stable(I_TX_DMA_NEXT_COUNT)
        |=> O_RDATA[BIT_TX_DMA_ZERO] == ($past(I_TX_DMA_COUNT | I_TX_DMA_NEXT_COUNT) == '0))
        else $error("tx count zero flag wrong");
    mask_set_a: assert property (wr_mask(OFS_IRQ_SET)
        |=> (O_RDATA[11:0] & $past(I_WDATA[11:0], 3)) == $past(I_WDATA[11:0], 3)) else $error("set lost");
    mask_clear_a: assert property (wr_mask(OFS_IRQ_CLR)
        |=> (O_RDATA[11:0] & $past(I_WDATA[11:0], 3)) == 12'h000) else $error("clear lost");
endmodule

bind ssr_regs ssr_checker #(.CNT_W(CNT_W)) chk_i (.*);

// *** tb_top.sv ***
module tb_top
    import ssr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLK = 0, I_RESET = 1, I_WR = 0, I_RD = 0;
    logic [ADDR_W-1:0] I_ADDR = '0;
    logic [31:0] I_WDATA = '0, rv;
    logic [10:0] pl = '0;
    logic [15:0] txc = '0, txn = '0, rxc = '0, rxn = '0;
    logic [ADDR_W-1:0] wa[4] = '{OFS_IRQ_SET, OFS_IRQ_SET, OFS_IRQ_CLR, OFS_IRQ_MASK};
    logic [31:0] wd[4] = '{32'h0a5, 32'h100, 32'h005, 32'hfff};
    logic [31:0] we[4] = '{32'h0a5, 32'h1a5, 32'h1a0, 32'h1a0};
    wire logic [31:0] O_RDATA;
    wire logic O_IRQ, O_TX_ENABLED, O_RX_ENABLED;
    int fails = 0, checks = 0;
    always #5 I_CLK = ~I_CLK;
    ssr_regs uut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .I_TX_HOLD_LOAD(pl[0]), .I_TX_SHIFT_TAKE(pl[1]),
        .I_TX_SHIFT_DONE(pl[2]), .I_RX_WORD_IN(pl[3]), .I_RX_WORD_READ(pl[4]), .I_TX_DMA_COUNT(txc),
        .I_TX_DMA_NEXT_COUNT(txn), .I_RX_DMA_COUNT(rxc), .I_RX_DMA_NEXT_COUNT(rxn),
        .I_TX_COUNT_WRITE(pl[5]), .I_RX_COUNT_WRITE(pl[6]), .I_CMP0_HIT(pl[7]), .I_CMP1_HIT(pl[8]),
        .I_TX_SYNC_EV(pl[9]), .I_RX_SYNC_EV(pl[10]), .O_TX_ENABLED(O_TX_ENABLED), .O_RX_ENABLED(O_RX_ENABLED));
    task complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task rd(input logic [ADDR_W-1:0] a);
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
        rv = O_RDATA;
    endtask
    task st(input logic [31:0] m, input logic [31:0] e);
        rd(OFS_STATUS);
        chk(rv & m, e, "status");
    endtask
    task pulse(input int b, input int n);
        @(posedge I_CLK);
        pl[b] <= 1'b1;
        repeat (n) @(posedge I_CLK);
        pl[b] <= 1'b0;
    endtask
    // irq is registered, so give the cause two edges to show
    task iq(input logic e);
        repeat (2) @(posedge I_CLK);
        #1;
        chk({31'h0, O_IRQ}, {31'h0, e}, "irq");
    endtask
    initial begin
        #50000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge I_CLK);
        I_RESET <= 1'b0;
        st(32'hfff, 32'h08b); // reset view
        rd(OFS_IRQ_MASK);
        chk(rv, 32'h0, "mask reset"); // mask reset
        pulse(0, 1);
        st(32'h3, 32'h0); // word waiting
        pulse(1, 1);
        st(32'h3, 32'h1); // shifter busy
        pulse(2, 1);
        st(32'h3, 32'h3); // all sent
        @(posedge I_CLK) txc <= 16'h5;
        st(32'hc, 32'h0); // count running
        @(posedge I_CLK) txc <= 16'h0;
        st(32'hc, 32'hc); // count done
        @(posedge I_CLK) txn <= 16'h7;
        st(32'h8, 32'h0); // next count pending
        pulse(5, 1);
        st(32'h4, 32'h0); // cleared by count write
        @(posedge I_CLK) rxc <= 16'h3;
        @(posedge I_CLK) rxc <= 16'h0;
        st(32'hc0, 32'hc0); // rx count done
        @(posedge I_CLK) rxn <= 16'h2;
        st(32'h80, 32'h0); // next count pending
        pulse(6, 1);
        st(32'h40, 32'h0); // cleared by count write
        @(posedge I_CLK) rxn <= 16'h0;
        pulse(3, 2);
        st(32'h30, 32'h30); // second word unread
        st(32'h30, 32'h10); // cleared by read
        pulse(4, 1);
        st(32'h10, 32'h0); // holding read
        for (int i = 7; i < 11; i++) begin
            pulse(i, 1);
            st(32'h1 << (i + 1), 32'h1 << (i + 1)); // event latched
            st(32'h1 << (i + 1), 32'h0); // cleared by read
        end
        for (int i = 0; i < 4; i++) begin
            wr(wa[i], wd[i]);
            rd(OFS_IRQ_MASK);
            chk(rv, we[i], "mask"); // set and clear
        end
        rd(4'hf);
        chk(rv, 32'h0, "unmapped");
        iq(1'b1); // rx counts zero enabled
        wr(OFS_IRQ_CLR, 32'hfff);
        iq(1'b0); // all masked
        wr(OFS_IRQ_SET, 32'h10);
        iq(1'b0); // rx empty
        pulse(3, 1);
        iq(1'b1); // rx word in
        pulse(4, 1);
        iq(1'b0); // rx word read
        wr(OFS_CTRL, 32'h3);
        st(32'h30000, 32'h30000);
        chk({30'h0, O_RX_ENABLED, O_TX_ENABLED}, 32'h3, "enables");
        rd(OFS_CTRL);
        chk(rv, 32'h3, "ctrl readback");
        complete_run();
    end
endmodule
